// >>> hdl/bledc_indicator.v
`timescale 1ns/10ps
`include "bledc_defs.vh"

// ----------------------------------------
// Three-stage pin synchroniser
// ----------------------------------------
// Stage one may go metastable, so only stages two and three are compared.
// A level must stand for two edges before it is passed on, which also
// filters single-cycle glitches on the slow sensor pins.
// Output resets low, the idle level of every pin it serves.
module bledc_sync3 (
  input wire clk,
  input wire reset_n,
  input wire d,
  output reg q
);
  reg s1_r;
  reg s2_r;
  reg s3_r;
  // Change accepted once stages two and three agree
  always @(posedge clk) begin
    if (!reset_n) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
      q <= 1'b0;
    end else begin
      s1_r <= d;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r) begin
        q <= s3_r;
      end
    end
  end
endmodule // bledc_sync3

module bledc_indicator (
  input wire clk,
  input wire reset_n,
  input wire fatal_fault,
  input wire cpu_catastrophic_error,
  input wire noncrit_fault,
  input wire degraded,
  input wire boot_start,
  input wire bmc_reset_event,
  input wire ctrl_mem_fail,
  input wire boot_images_bad,
  input wire loader_running,
  input wire main_fw_running,
  input wire boot_done,
  input wire post_wr,
  input wire [7:0] post_code,
  input wire [7:0] fan_lc_event,
  input wire fan_rearm,
  input wire dimm_fault_cmd,
  input wire [2:0] dimm_fault_slot,
  input wire sys_powered_on,
  output reg [1:0] status_led,
  output reg identification_led,
  output reg [7:0] post_led,
  output reg [7:0] fan_fault_led,
  output reg [7:0] dimm_fault_led,
  output wire [2:0] boot_state
);
  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  // Fault and fan sensor lines come from pins; firmware strobes are on this clock
  wire fatal_s;
  wire cpu_catastrophic_error_s;
  wire noncrit_s;
  wire degraded_s;
  wire [7:0] fan_s;
  bledc_sync3 u_sync_fatal (
    .clk(clk),
    .reset_n(reset_n),
    .d(fatal_fault),
    .q(fatal_s)
  );
  bledc_sync3 u_sync_cpu_catastrophic_error (
    .clk(clk),
    .reset_n(reset_n),
    .d(cpu_catastrophic_error),
    .q(cpu_catastrophic_error_s)
  );
  bledc_sync3 u_sync_noncrit (
    .clk(clk),
    .reset_n(reset_n),
    .d(noncrit_fault),
    .q(noncrit_s)
  );
  bledc_sync3 u_sync_degr (
    .clk(clk),
    .reset_n(reset_n),
    .d(degraded),
    .q(degraded_s)
  );
  genvar gi;
  generate
    for (gi = 0; gi < `BLEDC_FAN_N; gi = gi + 1) begin : g_fan
      bledc_sync3 u_sync_fan (
        .clk(clk),
        .reset_n(reset_n),
        .d(fan_lc_event[gi]),
        .q(fan_s[gi])
      );
    end
  endgenerate

  // ----------------------------------------
  // Blink dividers
  // ----------------------------------------
  // Half periods are worked out at full integer width, then cut to the
  // counter width on purpose; 28 bits cover the slow half at 200 MHz.
  // A faster clock needs a wider counter, or the divide silently wraps.
  // For simulation the rates in the defs header may be raised.
  localparam integer SLOW_HALF_I = `BLEDC_SLOW_HALF;
  localparam integer FAST_HALF_I = `BLEDC_FAST_HALF;
  localparam [27:0] SLOW_HALF = SLOW_HALF_I[27:0];
  localparam [27:0] FAST_HALF = FAST_HALF_I[27:0];
  reg [27:0] slow_cnt_r;
  reg [27:0] fast_cnt_r;
  reg slow_ph_r;
  reg fast_ph_r;
  // Equal on and off halves give 50 percent duty
  // Both dividers free-run; a phase is never restarted mid-blink
  always @(posedge clk) begin
    if (!reset_n) begin
      slow_cnt_r <= 28'h0000000;
      fast_cnt_r <= 28'h0000000;
      slow_ph_r <= 1'b0;
      fast_ph_r <= 1'b0;
    end else begin
      if (slow_cnt_r == SLOW_HALF - 28'h0000001) begin
        slow_cnt_r <= 28'h0000000;
        slow_ph_r <= ~slow_ph_r;
      end else begin
        slow_cnt_r <= slow_cnt_r + 28'h0000001;
      end
      if (fast_cnt_r == FAST_HALF - 28'h0000001) begin
        fast_cnt_r <= 28'h0000000;
        fast_ph_r <= ~fast_ph_r;
      end else begin
        fast_cnt_r <= fast_cnt_r + 28'h0000001;
      end
    end
  end

  // ----------------------------------------
  // Boot / reset sequence
  // ----------------------------------------
  // One-hot; reset itself stands for supply first applied
  localparam [4:0] ST_LOADER = 5'h01;
  localparam [4:0] ST_MAINFW = 5'h02;
  localparam [4:0] ST_NORMAL = 5'h04;
  localparam [4:0] ST_DEAD = 5'h08;
  localparam [4:0] ST_IDLE = 5'h10;
  // Idle is kept but never entered; reset and illegal codes go straight to the loader
  // stage because supply-on is the first boot. Fail conditions are checked
  // first in every live state, so a bad image cannot be masked by a
  // restart strobe in the same cycle. Restart in turn beats stage advance.
  reg [4:0] state_r;
  reg [4:0] state_nxt;

  // Dead state is sticky: only supply reset leaves it
  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_DEAD: state_nxt = ST_DEAD;
      ST_IDLE, ST_LOADER, ST_MAINFW, ST_NORMAL: begin
        if (ctrl_mem_fail || boot_images_bad) begin
          state_nxt = ST_DEAD;
        end else if (boot_start || bmc_reset_event) begin
          state_nxt = ST_LOADER;
        end else if (state_r == ST_LOADER && main_fw_running) begin
          state_nxt = ST_MAINFW;
        end else if ((state_r == ST_MAINFW || state_r == ST_LOADER) && boot_done) begin
          state_nxt = ST_NORMAL;
        end else if (state_r == ST_IDLE && loader_running) begin
          state_nxt = ST_LOADER;
        end
      end
      default: state_nxt = ST_LOADER;
    endcase
  end

  always @(posedge clk) begin
    if (!reset_n) begin
      state_r <= ST_LOADER;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Visible stage: normal, main firmware, loader; all low in dead or idle
  assign boot_state = {state_r[2], state_r[1], state_r[0]};

  // ----------------------------------------
  // Status and identification LEDs
  // ----------------------------------------
  reg [1:0] status_nxt;
  reg ident_nxt;
  // Severity order: fatal, non-fatal critical, degraded, healthy
  // Status blinks share the slow divider so green and amber never beat against
  // each other; the cost is that a blink starts wherever the free-running phase stands, on or off.
  // The identification LED is left to the stage; fatal only recolours
  // the status LED.
  always @* begin
    status_nxt = `BLEDC_COL_GREEN;
    ident_nxt = 1'b0;
    case (state_r)
      ST_DEAD: begin
        status_nxt = `BLEDC_COL_AMBER;
        ident_nxt = 1'b1;
      end
      ST_LOADER: begin
        status_nxt = slow_ph_r ? `BLEDC_COL_GREEN : `BLEDC_COL_OFF;
        ident_nxt = fast_ph_r;
      end
      ST_MAINFW: begin
        status_nxt = `BLEDC_COL_GREEN;
        ident_nxt = 1'b1;
      end
      ST_NORMAL, ST_IDLE: begin
        ident_nxt = 1'b0;
        if (noncrit_s) begin
          status_nxt = slow_ph_r ? `BLEDC_COL_AMBER : `BLEDC_COL_OFF;
        end else if (degraded_s) begin
          status_nxt = slow_ph_r ? `BLEDC_COL_GREEN : `BLEDC_COL_OFF;
        end else begin
          status_nxt = `BLEDC_COL_GREEN;
        end
      end
      default: begin
        status_nxt = `BLEDC_COL_GREEN;
        ident_nxt = 1'b0;
      end
    endcase
    // Fatal overrides every other state
    if (fatal_s || cpu_catastrophic_error_s) begin
      status_nxt = `BLEDC_COL_AMBER;
    end
  end

  always @(posedge clk) begin
    if (!reset_n) begin
      status_led <= `BLEDC_COL_OFF;
      identification_led <= 1'b0;
    end else begin
      status_led <= status_nxt;
      identification_led <= ident_nxt;
    end
  end

  // ----------------------------------------
  // POST code, fan and memory fault LEDs
  // ----------------------------------------
  // Slot faults are remembered while the system is off and shown on the
  // next power-on; only reset forgets them, firmware has no clear.
  // The post code is taken whole from one strobe, no byte pairing.
  reg [7:0] dimm_fault_r;
  integer k;
  // Fan set wins over a same-cycle re-arm so no event is lost
  // Re-arm reloads from the live synced levels: a fan still below its
  // limit stays lit rather than flashing off for a cycle.
  always @(posedge clk) begin
    if (!reset_n) begin
      post_led <= `BLEDC_POST_RST;
      fan_fault_led <= 8'h00;
      dimm_fault_r <= 8'h00;
      dimm_fault_led <= 8'h00;
    end else begin
      if (post_wr) begin
        post_led <= post_code;
      end
      if (fan_rearm) begin
        fan_fault_led <= fan_s;
      end else begin
        fan_fault_led <= fan_fault_led | fan_s;
      end
      // Slot faults only set by command, never cleared on our own
      for (k = 0; k < `BLEDC_DIMM_N; k = k + 1) begin
        if (dimm_fault_cmd && dimm_fault_slot == k[2:0]) begin
          dimm_fault_r[k] <= 1'b1;
        end
      end
      dimm_fault_led <= sys_powered_on ? dimm_fault_r : 8'h00;
    end
  end
endmodule // bledc_indicator

// >>> hdl/bledc_defs.vh
`ifndef BLEDC_DEFS_VH
`define BLEDC_DEFS_VH
// ----------------------------------------
// Timing
// ----------------------------------------
`define BLEDC_CLK_HZ 200000000
`define BLEDC_SLOW_HZ 1
`define BLEDC_FAST_HZ 3
// Half periods in clock cycles, 50 percent duty
`define BLEDC_SLOW_HALF (`BLEDC_CLK_HZ / (2 * `BLEDC_SLOW_HZ))
`define BLEDC_FAST_HALF (`BLEDC_CLK_HZ / (2 * `BLEDC_FAST_HZ))
// ----------------------------------------
// Sizes and reset values
// ----------------------------------------
`define BLEDC_FAN_N 8
`define BLEDC_DIMM_N 8
`define BLEDC_POST_W 8
`define BLEDC_POST_RST 8'h00
// Status colour code: bit 0 green, bit 1 amber
`define BLEDC_COL_OFF 2'h0
`define BLEDC_COL_GREEN 2'h1
`define BLEDC_COL_AMBER 2'h2
`endif

// >>> verif/bledc_ind_assertions.sv
`timescale 1ns/10ps
// ----------------------------------------
// Port checker
// ----------------------------------------
module bledc_ind_chk (
  input wire clk, reset_n, post_wr, fan_rearm, sys_powered_on, fatal_fault,
  input wire cpu_catastrophic_error, ctrl_mem_fail, boot_images_bad, boot_done,
  input wire main_fw_running, bmc_reset_event, boot_start, identification_led,
  input wire [7:0] post_code, post_led, fan_fault_led, dimm_fault_led,
  input wire [1:0] status_led,
  input wire [2:0] boot_state
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // Fail beats restart, restart beats advance
  wire fail = ctrl_mem_fail | boot_images_bad;
  wire jump = fail | boot_start | bmc_reset_event;
  // Dead state shows blue and amber; the hold is checked for four cycles
  sequence dead_lit; identification_led && status_led == 2'h2; endsequence
  sequence dead_hold; dead_lit [*4]; endsequence
  a_post_hold: assert property (post_wr |=> post_led == $past(post_code))
    else $error("post code not shown");
  a_fan_sticky: assert property (!fan_rearm |=>
    (fan_fault_led & $past(fan_fault_led)) == $past(fan_fault_led))
    else $error("fan fault led dropped without rearm");
  a_dimm_dark: assert property (!sys_powered_on [*2] |=> dimm_fault_led == 8'h00)
    else $error("memory fault led lit while off");
  a_fatal_amber: assert property (fatal_fault [*8] |-> status_led == 2'h2)
    else $error("fatal not amber");
  a_cpu_amber: assert property (cpu_catastrophic_error [*8] |-> status_led == 2'h2)
    else $error("cpu error not amber");
  a_dead_lit: assert property (fail |-> ##2 dead_hold)
    else $error("dead state not shown");
  a_done_off: assert property (boot_done && |boot_state[1:0] && !jump |->
    ##1 boot_state == 3'h4 ##1 !identification_led)
    else $error("boot end not shown");
  a_main_solid: assert property (main_fw_running && boot_state == 3'h1 && !jump
    && !boot_done |-> ##1 boot_state == 3'h2 ##1 identification_led)
    else $error("main firmware stage not shown");
  a_restart_load: assert property ((boot_start || bmc_reset_event) && !fail
    && boot_state != 3'h0 |=> boot_state == 3'h1)
    else $error("restart did not enter loader");
endmodule // bledc_ind_chk

bind bledc_indicator bledc_ind_chk u_chk (.*);

// >>> verif/bledc_led_panel.sv
`timescale 1ns/10ps
// ----------------------------------------
// Front panel lamps
// ----------------------------------------
module bledc_led_panel (
  input wire [1:0] status_led,
  input wire identification_led,
  output wire amber_on, green_on, blue_on
);
  // Both dies lit is no legal colour, so neither reads as lit
  assign green_on = status_led == 2'h1;
  assign amber_on = status_led == 2'h2;
  assign blue_on = identification_led;
endmodule // bledc_led_panel

// >>> verif/board_led_indicator_control_tb_top.sv
`timescale 1ns/10ps
module board_led_indicator_control_tb_top;
  logic clk = 0, reset_n = 0, post_wr = 0, sys_powered_on = 0, fatal_fault = 0;
  logic cpu_catastrophic_error = 0, noncrit_fault = 0, degraded = 0;
  logic boot_start = 0, loader_running = 0, identification_led, amber_on, green_on, blue_on;
  logic [6:0] st = 7'h00;
  logic [7:0] post_code = 8'h00, fan_lc_event = 8'h00, post_led, fan_fault_led, dimm_fault_led;
  logic [2:0] dimm_fault_slot = 3'h0, boot_state;
  logic [1:0] status_led;
  logic [15:0] rs = 16'he8a6;
  logic [7:0] pq[$];
  int fails = 0, cmp_count = 0, cyc_n = 0, j;
  // Strobes other than boot_start and post_wr share one vector so one task pulses any of them
  wire main_fw_running = st[0], boot_done = st[1], bmc_reset_event = st[2];
  wire ctrl_mem_fail = st[3], boot_images_bad = st[4], fan_rearm = st[5];
  wire dimm_fault_cmd = st[6];
  bledc_indicator DUT (.*);
  bledc_led_panel u_panel (.*);
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  always #2.5 clk = ~clk;
  task chk(input string n, input logic [7:0] s, e);
    cmp_count++;
    if (s !== e) begin
      fails++;
      $display("BAD %s exp %h seen %h", n, e, s);
    end
  endtask
  task w(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  function void xs();
    rs ^= rs << 7;
    rs ^= rs >> 9;
    rs ^= rs << 8;
  endfunction
  // Two edges after release the outputs have settled
  task pulse(input int k);
    @(posedge clk) st[k] <= 1;
    @(posedge clk) st[k] <= 0;
    w(2);
  endtask
  task rst();
    @(posedge clk) reset_n <= 0;
    repeat (2) @(posedge clk);
    reset_n <= 1;
  endtask
  task tally_and_finish();
    $display("checks %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Post code shows one edge after the write, checked mid-cycle
  logic pw_q = 0;
  always @(posedge clk) pw_q <= post_wr && reset_n;
  always @(negedge clk) if (pw_q) chk("post", post_led, pq.pop_front());
  // Hang guard, far above the roughly 140 cycles needed
  always @(posedge clk) begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == 2000) begin
      fails++;
      tally_and_finish();
    end
  end
  // Main sequence
  initial begin
    repeat (2) @(posedge clk);
    reset_n <= 1;
    w(1);
    chk("state", boot_state, 3'h1);
    for (j = 0; j < 4; j++) begin
      @(posedge clk);
      xs();
      post_wr <= 1;
      post_code <= rs[7:0];
      pq.push_back(rs[7:0]);
    end
    @(posedge clk) post_wr <= 0;
    pulse(0);
    chk("blue", blue_on, 1);
    chk("green", green_on, 1);
    pulse(1);
    chk("blue", blue_on, 0);
    chk("green", green_on, 1);
    @(posedge clk) fan_lc_event <= rs[7:0] | 8'h01;
    w(8);
    chk("fan", fan_fault_led, rs[7:0] | 8'h01);
    @(posedge clk) fan_lc_event <= 8'h00;
    w(8);
    chk("fan", fan_fault_led, rs[7:0] | 8'h01);
    pulse(5);
    chk("fan", fan_fault_led, 8'h00);
    for (j = 0; j < 2; j++) begin
      @(posedge clk);
      fatal_fault <= j == 0;
      cpu_catastrophic_error <= j == 1;
      w(8);
      chk("amber", amber_on, 1);
    end
    @(posedge clk) cpu_catastrophic_error <= 0;
    w(8);
    chk("green", green_on, 1);
    // The slow phase has not turned yet this early, so a fresh fault first shows dark
    @(posedge clk) noncrit_fault <= 1;
    w(8);
    chk("status", status_led, 8'h00);
    @(posedge clk) {noncrit_fault, degraded} <= 2'b01;
    w(8);
    chk("status", status_led, 8'h00);
    @(posedge clk) degraded <= 0;
    w(8);
    chk("green", green_on, 1);
    @(posedge clk) dimm_fault_slot <= 3'h3;
    pulse(6);
    chk("dimm", dimm_fault_led, 8'h00);
    @(posedge clk) sys_powered_on <= 1;
    w(3);
    chk("dimm", dimm_fault_led, 8'h08);
    @(posedge clk) dimm_fault_slot <= 3'h5;
    pulse(6);
    chk("dimm", dimm_fault_led, 8'h28);
    pulse(2);
    chk("state", boot_state, 3'h1);
    chk("blue", blue_on, 0);
    chk("status", status_led, 8'h00);
    pulse(1);
    @(posedge clk) boot_start <= 1;
    @(posedge clk) boot_start <= 0;
    w(2);
    chk("state", boot_state, 3'h1);
    for (j = 3; j < 5; j++) begin
      rst();
      pulse(j);
      pulse(1);
      chk("blue", blue_on, 1);
      chk("amber", amber_on, 1);
    end
    tally_and_finish();
  end
endmodule // board_led_indicator_control_tb_top
